// >>> rtl/usbep_ctrl.v
// endpoint 0 control transfer engine and interrupt enable registers
// assumes a packet layer that decodes tokens and data packets, checks
// crc, and sends the handshake or data packet this block asks for
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
`include "usbep_map.vh"

module usbep_ctrl (
   // clock and reset
   input wire clk,
   input wire resetn,
   // register port
   input wire [7:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [7:0] reg_rdata,
   // token decoded by the packet layer
   input wire tok_valid,
   input wire [1:0] tok_type,
   input wire tok_ep0,
   // received data packet for endpoint 0
   input wire rx_done,
   input wire rx_ok,
   input wire rx_data1,
   input wire [6:0] rx_len,
   // transmitted packet outcome
   input wire tx_done,
   input wire tx_ack,
   // pending flags kept elsewhere
   input wire [3:0] common_pend,
   input wire [3:1] out_ep_pend,
   // link answers
   output reg hs_valid,
   output reg [1:0] hs_code,
   output reg tx_start,
   output reg [6:0] tx_len,
   // processor side
   output reg ep0_irq,
   output wire irq
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   localparam [1:0] MODE_IDLE = 2'd0;
   localparam [1:0] MODE_TX = 2'd1;
   localparam [1:0] MODE_RX = 2'd2;
   localparam [1:0] MODE_STATUS = 2'd3;
   localparam [7:0] OUT_EN_RESET = `USBEP_OUT_IRQ_EN_RESET;
   localparam [7:0] COMMON_EN_RESET = `USBEP_COMMON_IRQ_EN_RESET;

   reg [1:0] mode;
   reg [1:0] next_mode;
   reg in_dir;
   reg next_in_dir;
   reg out_ready;
   reg in_ready;
   reg sent_stall;
   reg data_end_a;
   reg setup_end;
   reg send_stall;
   reg [6:0] byte_count;
   reg [6:0] in_len;
   reg [7:0] index;
   reg [3:1] out_irq_en;
   reg [3:0] common_irq_en;
   reg ep0_pend;
   reg tx_busy;
   reg tx_status;

   // ----------------------------------------------------------------
   // register decode
   // ----------------------------------------------------------------
   wire ep0_sel = (index == 8'h00);
   wire wr_ctrl = reg_wr && (reg_addr == `USBEP_ADDR_EP0_CTRL) && ep0_sel;
   wire rd_irq_status = reg_rd && (reg_addr == `USBEP_ADDR_EP0_IRQ_STATUS);
   wire [7:0] ctrl_view = {2'b00, send_stall, setup_end, data_end_a,
                           sent_stall, in_ready, out_ready};

   // ----------------------------------------------------------------
   // transaction engine: combinational outcome of each event
   // ----------------------------------------------------------------
   reg ev_irq;
   reg ev_stall;
   reg ev_setup_end;
   reg ev_out_set;
   reg ev_in_clr;
   reg ev_de_clr;
   reg ev_count;
   reg ev_hs;
   reg [1:0] ev_code;
   reg ev_tx;
   reg [6:0] ev_tx_len;
   reg ev_tx_status;

   always @* begin
      next_mode = mode;
      next_in_dir = in_dir;
      ev_irq = 1'b0;
      ev_stall = 1'b0;
      ev_setup_end = 1'b0;
      ev_out_set = 1'b0;
      ev_in_clr = 1'b0;
      ev_de_clr = 1'b0;
      ev_count = 1'b0;
      ev_hs = 1'b0;
      ev_code = `USBEP_HS_ACK;
      ev_tx = 1'b0;
      ev_tx_len = 7'h00;
      ev_tx_status = 1'b0;
      if (tok_valid && tok_ep0) begin
         if (send_stall) begin
            ev_stall = 1'b1;
         end else begin
            case (tok_type)
               `USBEP_TOK_SETUP: begin
                  if ((mode == MODE_TX || mode == MODE_RX) && !data_end_a) begin
                     ev_setup_end = 1'b1;
                  end
                  next_mode = MODE_IDLE;
                  ev_de_clr = 1'b1;
               end
               `USBEP_TOK_OUT: begin
                  case (mode)
                     MODE_TX: begin
                        if (!data_end_a) begin
                           ev_setup_end = 1'b1;
                        end
                        next_mode = MODE_STATUS;
                        next_in_dir = 1'b1;
                     end
                     MODE_RX: begin
                        if (data_end_a) begin
                           ev_stall = 1'b1;
                        end
                     end
                     MODE_IDLE: begin
                        next_mode = MODE_RX;
                        next_in_dir = 1'b0;
                     end
                     default: begin
                        if (!in_dir) begin
                           ev_stall = 1'b1;
                        end
                     end
                  endcase
               end
               `USBEP_TOK_IN: begin
                  if (mode == MODE_RX && !data_end_a) begin
                     ev_setup_end = 1'b1;
                     next_mode = MODE_IDLE;
                  end else if (mode == MODE_RX || (mode == MODE_STATUS && !in_dir)) begin
                     // zero-length status packet of an out transfer
                     next_mode = MODE_STATUS;
                     next_in_dir = 1'b0;
                     ev_tx = 1'b1;
                     ev_tx_status = 1'b1;
                  end else if (mode == MODE_STATUS) begin
                     ev_stall = 1'b1;
                  end else if (!in_ready) begin
                     ev_hs = 1'b1;
                     ev_code = `USBEP_HS_NAK;
                  end else begin
                     next_mode = MODE_TX;
                     next_in_dir = 1'b1;
                     ev_tx = 1'b1;
                     ev_tx_len = in_len;
                  end
               end
               default: begin
                  ev_hs = 1'b0;
               end
            endcase
         end
      end else if (rx_done && rx_ok) begin
         if (tok_type == `USBEP_TOK_SETUP) begin
            if (rx_len == `USBEP_SETUP_LEN) begin
               ev_out_set = 1'b1;
               ev_count = 1'b1;
               ev_hs = 1'b1;
               ev_irq = 1'b1;
            end
         end else if (rx_len > `USBEP_EP0_MAX_PACKET) begin
            ev_stall = 1'b1;
         end else if (mode == MODE_STATUS && in_dir) begin
            if (rx_data1 && rx_len != 7'h00) begin
               ev_stall = 1'b1;
            end else begin
               ev_hs = 1'b1;
               ev_irq = 1'b1;
               ev_de_clr = 1'b1;
               next_mode = MODE_IDLE;
            end
         end else if (out_ready) begin
            ev_hs = 1'b1;
            ev_code = `USBEP_HS_NAK;
         end else begin
            ev_out_set = 1'b1;
            ev_count = 1'b1;
            ev_hs = 1'b1;
            ev_irq = 1'b1;
            if (rx_len < `USBEP_EP0_MAX_PACKET && data_end_a) begin
               next_mode = MODE_STATUS;
               next_in_dir = 1'b0;
            end
         end
      end else if (tx_done && tx_busy) begin
         if (tx_ack) begin
            ev_irq = 1'b1;
            if (tx_status) begin
               ev_de_clr = 1'b1;
               next_mode = MODE_IDLE;
            end else begin
               ev_in_clr = 1'b1;
               if (in_len < `USBEP_EP0_MAX_PACKET && data_end_a) begin
                  next_mode = MODE_STATUS;
               end
            end
         end
      end
      if (ev_stall) begin
         ev_hs = 1'b1;
         ev_code = `USBEP_HS_STALL;
         ev_irq = 1'b1;
         ev_tx = 1'b0;
         next_mode = MODE_IDLE;
         ev_de_clr = 1'b1;
      end
      if (ev_setup_end) begin
         ev_irq = 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // endpoint 0 flags, mode and counts
   // ----------------------------------------------------------------
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         mode <= MODE_IDLE;
         in_dir <= 1'b0;
         out_ready <= 1'b0;
         in_ready <= 1'b0;
         sent_stall <= 1'b0;
         data_end_a <= 1'b0;
         setup_end <= 1'b0;
         send_stall <= 1'b0;
         byte_count <= 7'h00;
         in_len <= 7'h00;
         tx_busy <= 1'b0;
         tx_status <= 1'b0;
      end else begin
         mode <= next_mode;
         in_dir <= next_in_dir;
         // hardware sets win over firmware clears
         if (ev_out_set) begin
            out_ready <= 1'b1;
         end else if (wr_ctrl && reg_wdata[`USBEP_BIT_SERVICED_OUT]) begin
            out_ready <= 1'b0;
         end
         if (ev_in_clr) begin
            in_ready <= 1'b0;
         end else if (wr_ctrl && reg_wdata[`USBEP_BIT_IN_READY]) begin
            in_ready <= 1'b1;
         end
         if (ev_stall) begin
            sent_stall <= 1'b1;
         end else if (wr_ctrl && !reg_wdata[`USBEP_BIT_SENT_STALL]) begin
            sent_stall <= 1'b0;
         end
         if (ev_setup_end) begin
            setup_end <= 1'b1;
         end else if (wr_ctrl && reg_wdata[`USBEP_BIT_SERVICED_SETUP_END]) begin
            setup_end <= 1'b0;
         end
         if (wr_ctrl && reg_wdata[`USBEP_BIT_DATA_END]) begin
            data_end_a <= 1'b1;
         end else if (ev_de_clr) begin
            data_end_a <= 1'b0;
         end
         if (ev_stall) begin
            send_stall <= 1'b0;
         end else if (wr_ctrl) begin
            send_stall <= reg_wdata[`USBEP_BIT_SEND_STALL];
         end
         if (ev_count) begin
            byte_count <= rx_len;
         end else if (wr_ctrl && reg_wdata[`USBEP_BIT_SERVICED_OUT]) begin
            byte_count <= 7'h00;
         end
         if (reg_wr && reg_addr == `USBEP_ADDR_EP0_IN_LEN) begin
            in_len <= reg_wdata[6:0];
         end
         if (ev_tx) begin
            tx_busy <= 1'b1;
            tx_status <= ev_tx_status;
         end else if (tx_done) begin
            tx_busy <= 1'b0;
            tx_status <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // link answers and interrupt
   // ----------------------------------------------------------------
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         hs_valid <= 1'b0;
         hs_code <= `USBEP_HS_ACK;
         tx_start <= 1'b0;
         tx_len <= 7'h00;
         ep0_irq <= 1'b0;
         ep0_pend <= 1'b0;
      end else begin
         hs_valid <= ev_hs;
         hs_code <= ev_code;
         tx_start <= ev_tx;
         tx_len <= ev_tx_len;
         ep0_irq <= ev_irq;
         if (ev_irq) begin
            ep0_pend <= 1'b1;
         end else if (rd_irq_status) begin
            ep0_pend <= 1'b0;
         end
      end
   end

   assign irq = ep0_pend | (|(out_ep_pend & out_irq_en)) | (|(common_pend & common_irq_en));

   // ----------------------------------------------------------------
   // enable, index registers and read port
   // ----------------------------------------------------------------
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         index <= 8'h00;
         out_irq_en <= OUT_EN_RESET[3:1];
         common_irq_en <= COMMON_EN_RESET[3:0];
         reg_rdata <= 8'h00;
      end else begin
         if (reg_wr && reg_addr == `USBEP_ADDR_INDEX) begin
            index <= reg_wdata;
         end
         if (reg_wr && reg_addr == `USBEP_ADDR_OUT_IRQ_EN) begin
            out_irq_en <= reg_wdata[3:1];
         end
         if (reg_wr && reg_addr == `USBEP_ADDR_COMMON_IRQ_EN) begin
            common_irq_en <= reg_wdata[3:0];
         end
         reg_rdata <= 8'h00;
         if (reg_rd) begin
            case (reg_addr)
               `USBEP_ADDR_EP0_IRQ_STATUS: reg_rdata <= {7'h00, ep0_pend};
               `USBEP_ADDR_OUT_IRQ_EN: reg_rdata <= {4'h0, out_irq_en, 1'b0};
               `USBEP_ADDR_COMMON_IRQ_EN: reg_rdata <= {4'h0, common_irq_en};
               `USBEP_ADDR_INDEX: reg_rdata <= index;
               `USBEP_ADDR_EP0_CTRL: reg_rdata <= ep0_sel ? ctrl_view : 8'h00;
               `USBEP_ADDR_EP0_COUNT: reg_rdata <= {1'b0, byte_count};
               `USBEP_ADDR_EP0_IN_LEN: reg_rdata <= {1'b0, in_len};
               default: reg_rdata <= 8'h00;
            endcase
         end
      end
   end

endmodule

// >>> rtl/usbep_map.vh
// register offsets, field positions, reset values and packet figures
// for the endpoint 0 control and interrupt enable logic
// assumes an 8-bit register port with offsets as printed
`ifndef USBEP_MAP_VH
`define USBEP_MAP_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define USBEP_ADDR_EP0_IRQ_STATUS 8'h02
`define USBEP_ADDR_OUT_IRQ_EN 8'h09
`define USBEP_ADDR_COMMON_IRQ_EN 8'h0b
`define USBEP_ADDR_INDEX 8'h0e
`define USBEP_ADDR_EP0_CTRL 8'h11
`define USBEP_ADDR_EP0_COUNT 8'h16
`define USBEP_ADDR_EP0_IN_LEN 8'h17

// ----------------------------------------------------------------
// reset values and writable masks
// ----------------------------------------------------------------
`define USBEP_OUT_IRQ_EN_RESET 8'h0e
`define USBEP_OUT_IRQ_EN_MASK 8'h0e
`define USBEP_COMMON_IRQ_EN_RESET 8'h06
`define USBEP_COMMON_IRQ_EN_MASK 8'h0f

// ----------------------------------------------------------------
// ep0 control/status fields
// ----------------------------------------------------------------
`define USBEP_BIT_OUT_READY 0
`define USBEP_BIT_IN_READY 1
`define USBEP_BIT_SENT_STALL 2
`define USBEP_BIT_DATA_END 3
`define USBEP_BIT_SETUP_END 4
`define USBEP_BIT_SEND_STALL 5
`define USBEP_BIT_SERVICED_OUT 6
`define USBEP_BIT_SERVICED_SETUP_END 7

// ----------------------------------------------------------------
// packet figures and codes
// ----------------------------------------------------------------
`define USBEP_EP0_MAX_PACKET 7'h40
`define USBEP_SETUP_LEN 7'h08
`define USBEP_TOK_SETUP 2'h0
`define USBEP_TOK_OUT 2'h1
`define USBEP_TOK_IN 2'h2
`define USBEP_HS_ACK 2'h0
`define USBEP_HS_NAK 2'h1
`define USBEP_HS_STALL 2'h2

`endif

// >>> test/tb_usbep_ctrl.sv
// self-checking bench for the endpoint 0 control block
// assumes the host model on the link side and the map header visible
`timescale 1ns/1ps
`include "usbep_map.vh"

module tb_usbep_ctrl;
   reg clk = 1'b0;
   reg resetn = 1'b0;
   reg [7:0] reg_addr = 8'h00;
   reg [7:0] reg_wdata = 8'h00;
   reg reg_wr = 1'b0;
   reg reg_rd = 1'b0;
   reg [3:0] common_pend = 4'h0;
   reg [3:1] out_ep_pend = 3'h0;
   wire [7:0] reg_rdata;
   wire [1:0] tok_type, hs_code;
   wire [6:0] rx_len, tx_len;
   wire irq, tok_valid, tok_ep0, rx_done, rx_ok, rx_data1, tx_done, tx_ack, hs_valid, tx_start, ep0_irq;
   integer n_fail = 0;
   integer checks_done = 0;
   localparam [1:0] TOK = 2'h0, DAT = 2'h1, TXD = 2'h2;

   always #10 clk = ~clk;

   usbep_ctrl u_usbep_ctrl (.clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tok_valid(tok_valid), .tok_type(tok_type),
      .tok_ep0(tok_ep0), .rx_done(rx_done), .rx_ok(rx_ok), .rx_data1(rx_data1), .rx_len(rx_len),
      .tx_done(tx_done), .tx_ack(tx_ack), .common_pend(common_pend), .out_ep_pend(out_ep_pend),
      .hs_valid(hs_valid), .hs_code(hs_code), .tx_start(tx_start), .tx_len(tx_len), .ep0_irq(ep0_irq), .irq(irq));
   usbep_host_model u_usbep_host_model (.clk(clk), .tok_valid(tok_valid), .tok_type(tok_type), .tok_ep0(tok_ep0),
      .rx_done(rx_done), .rx_ok(rx_ok), .rx_data1(rx_data1), .rx_len(rx_len), .tx_done(tx_done), .tx_ack(tx_ack),
      .hs_valid(hs_valid), .hs_code(hs_code), .tx_start(tx_start), .tx_len(tx_len), .ep0_irq(ep0_irq));

   // ----------------------------------------------------------------
   // bus cycles and comparison
   // ----------------------------------------------------------------
   task chk(input [7:0] got, input [7:0] exp);
      begin
         checks_done = checks_done + 1;
         if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task wr(input [7:0] a, input [7:0] d);
      begin
         @(posedge clk);
         reg_wr <= 1'b1;
         reg_addr <= a;
         reg_wdata <= d;
         @(posedge clk);
         reg_wr <= 1'b0;
      end
   endtask
   task rd(input [7:0] a, input [7:0] m, input [7:0] exp);
      begin
         @(posedge clk);
         reg_rd <= 1'b1;
         reg_addr <= a;
         @(posedge clk);
         reg_rd <= 1'b0;
         #1 chk(reg_rdata & m, exp);
      end
   endtask
   task pend(input [3:0] c, input [3:1] o, input [7:0] exp);
      begin
         @(posedge clk);
         common_pend <= c;
         out_ep_pend <= o;
         #1 chk({7'h00, irq}, exp);
      end
   endtask
   task lk(input [1:0] kind, input [1:0] ty, input [6:0] len, input flag, input [7:0] exp);
      begin
         u_usbep_host_model.ev(kind, ty, len, flag);
         chk(u_usbep_host_model.ans, exp);
      end
   endtask
   task setup8;
      begin
         lk(TOK, `USBEP_TOK_SETUP, 7'h00, 1'b0, 8'h00);
         lk(DAT, 2'h0, 7'h08, 1'b1, 8'h81);
         wr(8'h11, 8'h40);
      end
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task t_regs;
      begin
         rd(8'h09, 8'hff, 8'h0e);
         rd(8'h0b, 8'hff, 8'h06);
         pend(4'h1, 3'h0, 8'h00);
         pend(4'h2, 3'h0, 8'h01);
         pend(4'h0, 3'h1, 8'h01);
         wr(8'h09, 8'hff);
         rd(8'h09, 8'hff, 8'h0e);
         wr(8'h09, 8'h00);
         pend(4'h0, 3'h1, 8'h00);
         wr(8'h0b, 8'hff);
         rd(8'h0b, 8'hff, 8'h0f);
         pend(4'h8, 3'h0, 8'h01);
         pend(4'h0, 3'h0, 8'h00);
         rd(8'h3f, 8'hff, 8'h00);
         wr(8'h0e, 8'h01);
         rd(8'h11, 8'hff, 8'h00);
         wr(8'h0e, 8'h00);
         $display("register test done");
      end
   endtask
   task t_setup;
      begin
         lk(TOK, `USBEP_TOK_SETUP, 7'h00, 1'b0, 8'h00);
         lk(DAT, 2'h0, 7'h08, 1'b1, 8'h81);
         rd(8'h16, 8'hff, 8'h08);
         rd(8'h11, 8'hff, 8'h01);
         rd(8'h02, 8'h01, 8'h01);
         wr(8'h11, 8'h40);
         rd(8'h11, 8'hff, 8'h00);
         lk(TOK, `USBEP_TOK_SETUP, 7'h00, 1'b0, 8'h00);
         lk(DAT, 2'h0, 7'h08, 1'b0, 8'h00);
         lk(TOK, `USBEP_TOK_SETUP, 7'h00, 1'b0, 8'h00);
         lk(DAT, 2'h0, 7'h07, 1'b1, 8'h00);
         setup8;
         lk(TOK, `USBEP_TOK_OUT, 7'h00, 1'b0, 8'h00);
         lk(DAT, 2'h1, 7'h41, 1'b1, 8'ha1);
         rd(8'h11, 8'hff, 8'h04);
         wr(8'h11, 8'h00);
         $display("setup test done");
      end
   endtask
   task t_in;
      begin
         setup8;
         lk(TOK, `USBEP_TOK_IN, 7'h00, 1'b0, 8'h90);
         wr(8'h17, 8'h05);
         wr(8'h11, 8'h0a);
         lk(TOK, `USBEP_TOK_IN, 7'h00, 1'b0, 8'h08);
         chk({1'b0, u_usbep_host_model.got_len}, 8'h05);
         lk(TXD, 2'h0, 7'h00, 1'b0, 8'h00);
         lk(TOK, `USBEP_TOK_IN, 7'h00, 1'b0, 8'h08);
         lk(TXD, 2'h0, 7'h00, 1'b1, 8'h01);
         rd(8'h11, 8'h02, 8'h00);
         lk(TOK, `USBEP_TOK_OUT, 7'h00, 1'b0, 8'h00);
         lk(DAT, 2'h1, 7'h02, 1'b1, 8'ha1);
         wr(8'h11, 8'h00);
         $display("in test done");
      end
   endtask
   task t_stall;
      begin
         wr(8'h11, 8'h20);
         lk(TOK, `USBEP_TOK_OUT, 7'h00, 1'b0, 8'ha1);
         rd(8'h11, 8'h24, 8'h04);
         wr(8'h11, 8'h00);
         $display("stall test done");
      end
   endtask
   task t_setup_end;
      begin
         setup8;
         wr(8'h17, 8'h40);
         wr(8'h11, 8'h02);
         lk(TOK, `USBEP_TOK_IN, 7'h00, 1'b0, 8'h08);
         chk({1'b0, u_usbep_host_model.got_len}, 8'h40);
         lk(TXD, 2'h0, 7'h00, 1'b1, 8'h01);
         lk(TOK, `USBEP_TOK_SETUP, 7'h00, 1'b0, 8'h01);
         rd(8'h11, 8'h10, 8'h10);
         wr(8'h11, 8'h80);
         rd(8'h11, 8'h10, 8'h00);
         $display("setup end test done");
      end
   endtask
   task t_phase;
      begin
         setup8;
         lk(TOK, `USBEP_TOK_OUT, 7'h00, 1'b0, 8'h00);
         lk(DAT, 2'h1, 7'h04, 1'b1, 8'h81);
         rd(8'h16, 8'hff, 8'h04);
         lk(TOK, `USBEP_TOK_OUT, 7'h00, 1'b0, 8'h00);
         lk(DAT, 2'h1, 7'h04, 1'b1, 8'h90);
         wr(8'h11, 8'h48);
         lk(TOK, `USBEP_TOK_OUT, 7'h00, 1'b0, 8'ha1);
         rd(8'h11, 8'h04, 8'h04);
         setup8;
         lk(TOK, `USBEP_TOK_OUT, 7'h00, 1'b0, 8'h00);
         wr(8'h11, 8'h08);
         lk(TOK, `USBEP_TOK_IN, 7'h00, 1'b0, 8'h08);
         lk(TXD, 2'h0, 7'h00, 1'b1, 8'h01);
         wr(8'h17, 8'h00);
         wr(8'h11, 8'h0a);
         lk(TOK, `USBEP_TOK_IN, 7'h00, 1'b0, 8'h08);
         lk(TXD, 2'h0, 7'h00, 1'b1, 8'h01);
         lk(TOK, `USBEP_TOK_IN, 7'h00, 1'b0, 8'ha1);
         setup8;
         wr(8'h11, 8'h0a);
         lk(TOK, `USBEP_TOK_IN, 7'h00, 1'b0, 8'h08);
         lk(TXD, 2'h0, 7'h00, 1'b1, 8'h01);
         lk(TOK, `USBEP_TOK_OUT, 7'h00, 1'b0, 8'h00);
         lk(DAT, 2'h1, 7'h00, 1'b1, 8'h81);
         $display("phase test done");
      end
   endtask

   task results;
      begin
         $display("checks %0d failures %0d", checks_done, n_fail);
         if (n_fail == 0 && checks_done > 0) begin
            $display("Simulation passed");
         end else begin
            $display("Simulation failed");
         end
         $finish;
      end
   endtask

   initial begin
      #500000;
      n_fail = n_fail + 1;
      results;
   end
   initial begin
      repeat (12) @(posedge clk);
      resetn <= 1'b1;
      t_regs;
      t_setup;
      t_in;
      t_stall;
      t_setup_end;
      t_phase;
      results;
   end
endmodule

bind usbep_ctrl usbep_ctrl_props u_usbep_ctrl_props (.clk(clk), .resetn(resetn), .tok_valid(tok_valid),
   .tok_type(tok_type), .tok_ep0(tok_ep0), .rx_done(rx_done), .rx_ok(rx_ok), .rx_len(rx_len), .tx_done(tx_done),
   .tx_ack(tx_ack), .common_pend(common_pend), .out_ep_pend(out_ep_pend), .hs_valid(hs_valid),
   .hs_code(hs_code), .tx_start(tx_start), .ep0_irq(ep0_irq), .irq(irq));

// >>> test/usbep_ctrl_properties.sv
// port-level timing checks for the endpoint 0 control block
// assumes one clock domain and the map header on the include path
`timescale 1ns/1ps
`include "usbep_map.vh"

module usbep_ctrl_props (
   // clock and reset
   input wire clk,
   input wire resetn,
   // link side and pending flags
   input wire tok_valid,
   input wire [1:0] tok_type,
   input wire tok_ep0,
   input wire rx_done,
   input wire rx_ok,
   input wire [6:0] rx_len,
   input wire tx_done,
   input wire tx_ack,
   input wire [3:0] common_pend,
   input wire [3:1] out_ep_pend,
   // answers
   input wire hs_valid,
   input wire [1:0] hs_code,
   input wire tx_start,
   input wire ep0_irq,
   input wire irq
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);
   // events in the priority order the block takes them
   wire tk = tok_valid && tok_ep0;
   wire rxg = rx_done && rx_ok && !tk;
   wire txg = tx_done && !tk && !(rx_done && rx_ok);

   property p_hs_cause; hs_valid |-> $past(tk || rxg); endproperty
   a_hs_cause: assert property (p_hs_cause) else $error("handshake without a cause");
   property p_bad_rx; rx_done && !rx_ok && !tk && !tx_done |=> !hs_valid && !ep0_irq; endproperty
   a_bad_rx: assert property (p_bad_rx) else $error("answer to a bad packet");
   property p_setup_len;
      rxg && tok_type == `USBEP_TOK_SETUP && rx_len != `USBEP_SETUP_LEN |=> !hs_valid && !ep0_irq;
   endproperty
   a_setup_len: assert property (p_setup_len) else $error("short setup not rejected");
   property p_stall_irq; hs_valid && hs_code == `USBEP_HS_STALL |-> ep0_irq; endproperty
   a_stall_irq: assert property (p_stall_irq) else $error("stall without interrupt");
   property p_nak_quiet; hs_valid && hs_code == `USBEP_HS_NAK |-> !ep0_irq; endproperty
   a_nak_quiet: assert property (p_nak_quiet) else $error("interrupt with nak");
   property p_noack; txg && !tx_ack |=> !ep0_irq && !hs_valid; endproperty
   a_noack: assert property (p_noack) else $error("interrupt without host ack");
   property p_tx_cause; tx_start |-> $past(tk && tok_type == `USBEP_TOK_IN); endproperty
   a_tx_cause: assert property (p_tx_cause) else $error("data sent without in token");
   property p_irq_cause; ep0_irq |-> $past(tk || rxg || (txg && tx_ack)); endproperty
   a_irq_cause: assert property (p_irq_cause) else $error("spurious endpoint interrupt");
   property p_irq_rise;
      $rose(irq) && common_pend == 4'h0 && out_ep_pend == 3'h0 |-> ep0_irq || $past(ep0_irq);
   endproperty
   a_irq_rise: assert property (p_irq_rise) else $error("interrupt line without pending cause");
endmodule

// >>> test/usbep_host_model.sv
// bus-side host: sends tokens, data packets and transmit outcomes
// assumes the device answers exactly one cycle after each event
`timescale 1ns/1ps

module usbep_host_model (
   // clock
   input wire clk,
   // link lines toward the device
   output reg tok_valid,
   output reg [1:0] tok_type,
   output reg tok_ep0,
   output reg rx_done,
   output reg rx_ok,
   output reg rx_data1,
   output reg [6:0] rx_len,
   output reg tx_done,
   output reg tx_ack,
   // device answers
   input wire hs_valid,
   input wire [1:0] hs_code,
   input wire tx_start,
   input wire [6:0] tx_len,
   input wire ep0_irq
);
   reg [7:0] ans;
   reg [6:0] got_len;
   initial begin
      {tok_valid, tok_ep0, rx_done, rx_ok, rx_data1, tx_done, tx_ack} = 7'h00;
      tok_type = 2'h0;
      rx_len = 7'h00;
   end
   // kind 0 token, 1 data packet, 2 transmit outcome
   task ev(input [1:0] kind, input [1:0] ty, input [6:0] len, input flag);
      begin
         @(posedge clk);
         if (kind == 2'h0) begin
            tok_valid <= 1'b1;
            tok_ep0 <= 1'b1;
            tok_type <= ty;
         end else if (kind == 2'h1) begin
            rx_done <= 1'b1;
            rx_ok <= flag;
            rx_data1 <= ty[0];
            rx_len <= len;
         end else begin
            tx_done <= 1'b1;
            tx_ack <= flag;
         end
         @(posedge clk);
         // released lines other than tok_type do not keep their last value
         {tok_valid, tok_ep0, rx_done, tx_done} <= 4'h0;
         rx_len <= ~rx_len;
         rx_ok <= ~rx_ok;
         rx_data1 <= ~rx_data1;
         tx_ack <= ~tx_ack;
         #1;
         ans = {hs_valid, 1'b0, hs_code & {2{hs_valid}}, tx_start, 2'b00, ep0_irq};
         got_len = tx_len;
      end
   endtask
endmodule
